// *** rtl/rpsr_pkg.sv ***
// Purpose: shared constants and types of the system register group
// Assumes: 8-bit register file addresses, 32 blocks of eight registers
// Notes: offsets are register file addresses, not bus byte addresses
package rpsr_pkg;

  // register file addresses of the system registers held here
  localparam logic [7:0] RPSR_OFS_FLAGS = 8'hE7;
  localparam logic [7:0] RPSR_OFS_PTR_LOW = 8'hE8;
  localparam logic [7:0] RPSR_OFS_PTR_HIGH = 8'hE9;
  localparam logic [7:0] RPSR_OFS_PAGE = 8'hEA;
  localparam logic [7:0] RPSR_OFS_MODE = 8'hEB;

  // values after reset
  localparam logic [7:0] RPSR_RST_FLAGS = 8'h00;
  localparam logic [4:0] RPSR_RST_BLOCK = 5'h00;
  localparam logic [5:0] RPSR_RST_PAGE = 6'h00;
  localparam logic [7:0] RPSR_RST_MODE = 8'hE0;

  // condition flag bit positions
  localparam int RPSR_FLAG_C = 7;
  localparam int RPSR_FLAG_Z = 6;
  localparam int RPSR_FLAG_S = 5;
  localparam int RPSR_FLAG_V = 4;
  localparam int RPSR_FLAG_DA = 3;
  localparam int RPSR_FLAG_H = 2;
  localparam int RPSR_FLAG_RSV = 1;
  localparam int RPSR_FLAG_DP = 0;

  // block pointer and page select field positions
  localparam int RPSR_PTR_BLK_MSB = 7;
  localparam int RPSR_PTR_BLK_LSB = 3;
  localparam int RPSR_PTR_TWIN = 2;
  localparam int RPSR_PAGE_MSB = 7;
  localparam int RPSR_PAGE_LSB = 2;

  // operating mode control bit positions
  localparam int RPSR_MODE_SSTK = 7;
  localparam int RPSR_MODE_USTK = 6;
  localparam int RPSR_MODE_HALF = 5;

  // register group that direct addressing may not reach
  localparam logic [3:0] RPSR_GROUP_D = 4'hD;

  // flag-affecting operation classes offered by the execution unit
  typedef enum logic [2:0] {
    RPSR_ALU_ADD,
    RPSR_ALU_SUB,
    RPSR_ALU_CMP,
    RPSR_ALU_LOGIC,
    RPSR_ALU_SHL,
    RPSR_ALU_SHR
  } rpsr_alu_e;

endpackage

// *** rtl/rpsr_flag_calc.sv ***
// Purpose: overflow, nibble carry and adjust direction for byte operations
// Assumes: operands and carry-in are stable in the cycle of the update
// Notes: purely combinational; the owner registers the results
`timescale 1ns/10ps
`default_nettype none
module rpsr_flag_calc (
  input wire logic [7:0] a,              // accumulator operand
  input wire logic [7:0] b,              // second operand
  input wire logic cin,                  // carry or borrow in
  input wire rpsr_pkg::rpsr_alu_e op,    // operation class
  output logic ovf,                      // signed result out of range
  output logic nib_carry,                // carry out of / borrow into bit 3
  output logic dir_sub,                  // last arithmetic was a subtraction
  output logic bcd_upd                   // op touches nibble and direction
);

  logic [7:0] sum;
  logic [7:0] dif;
  logic [4:0] nib_sum;
  logic [4:0] nib_sub;

  assign sum = a + b + {7'h00, cin};
  assign dif = a - b - {7'h00, cin};
  assign nib_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign nib_sub = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};

  always_comb
  begin
    ovf = 1'b0;
    nib_carry = 1'b0;
    dir_sub = 1'b0;
    bcd_upd = 1'b0;
    unique case (op)
      rpsr_pkg::RPSR_ALU_ADD:
      begin
        ovf = (a[7] == b[7]) && (sum[7] != a[7]);
        nib_carry = nib_sum[4];
        bcd_upd = 1'b1;
      end
      rpsr_pkg::RPSR_ALU_SUB:
      begin
        ovf = (a[7] != b[7]) && (dif[7] != a[7]);
        nib_carry = nib_sub[4];
        dir_sub = 1'b1;
        bcd_upd = 1'b1;
      end
      rpsr_pkg::RPSR_ALU_CMP:
        ovf = (a[7] != b[7]) && (dif[7] != a[7]);
      rpsr_pkg::RPSR_ALU_SHL:
        ovf = a[7] ^ a[6];
      rpsr_pkg::RPSR_ALU_LOGIC,
      rpsr_pkg::RPSR_ALU_SHR:
        ovf = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// *** rtl/rpsr_core.sv ***
// Purpose: condition flags, working register pointing, page select, mode
// Assumes: one core clock; instruction strobes come from the sequencer
// Notes: register file port uses 8-bit register addresses, read data late
`timescale 1ns/10ps
`default_nettype none
module rpsr_core #(
  parameter int NUM_BLOCKS = 32,         // eight-register blocks in the file
  parameter int NUM_PAGES = 64           // pages selectable for group F
) (
  input wire logic clk,                  // core clock, 100 MHz
  input wire logic rst,                  // synchronous reset, active high
  input wire logic ce,                   // clock enable, freezes all state
  input wire logic [7:0] reg_addr,       // register file address
  input wire logic [7:0] reg_wdata,      // register write data
  input wire logic reg_wr,               // register write strobe
  input wire logic reg_rd,               // register read strobe
  input wire logic reg_direct,           // access uses explicit addressing
  output logic reg_claim,                // address is one held here
  output logic [7:0] reg_rdata,          // read data, one cycle after read
  output logic reg_rvalid,               // read data valid pulse
  output logic reg_refused,              // direct access to group D pulse
  input wire logic op_srp,               // single pointer instruction
  input wire logic op_set_twin_pointer_low,              // set_twin_pointer_low instruction
  input wire logic op_set_twin_pointer_high,              // set_twin_pointer_high instruction
  input wire logic [4:0] op_block,       // block number operand
  input wire logic op_sdm,               // set data memory instruction
  input wire logic op_spm,               // set program memory instruction
  input wire logic alu_upd,              // flag-affecting operation done
  input wire rpsr_pkg::rpsr_alu_e alu_op,// class of that operation
  input wire logic [7:0] alu_a,          // accumulator operand
  input wire logic [7:0] alu_b,          // second operand
  input wire logic alu_cin,              // carry or borrow in
  input wire logic wr_req,               // working register access request
  input wire logic [3:0] wr_index,       // working register r0..r15
  output logic [7:0] wr_phys_addr,       // physical register file address
  output logic wr_phys_valid,            // address valid pulse
  output logic [7:0] condition_flags,    // flag register contents
  output logic memory_space_select_flag, // data accesses use data pages
  output logic twin_mode_select,         // 1: two 8-register blocks
  output logic [5:0] page_number_field,  // page mapped into group F
  output logic system_stack_location,    // 1: system stack in register file
  output logic user_stack_location,      // 1: user stack in register file
  output logic oscillator_halving,       // 1: oscillator divided by two
  output logic osc_clk_en                // oscillator enable after divider
);

  // the address arithmetic below is fixed to 8-bit register addresses
  if (NUM_BLOCKS != 32)
  begin : g_bad_blocks
    $error("rpsr_core: NUM_BLOCKS must be 32");
  end
  if (NUM_PAGES < 1 || NUM_PAGES > 64)
  begin : g_bad_pages
    $error("rpsr_core: NUM_PAGES must be 1..64");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_group_d(input logic [7:0] addr);
    in_group_d = (addr[7:4] == rpsr_pkg::RPSR_GROUP_D);
  endfunction

  // single: block bits 4:1 joined with all four index bits; twin: block joined with index bits 2:0
  function automatic logic [7:0] work_phys(
    input logic [3:0] idx,
    input logic [4:0] blk_lo,
    input logic [4:0] blk_hi,
    input logic twin
  );
    if (!twin)
      work_phys = {blk_lo[4:1], idx};
    else if (idx[3])
      work_phys = {blk_hi, idx[2:0]};
    else
      work_phys = {blk_lo, idx[2:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  logic refuse;
  logic wr_ok;
  logic sel_flags;
  logic sel_page;
  logic sel_mode;
  logic sel_ptr [2];

  // group D stays reachable through pointers and stacks only
  assign refuse = reg_direct && in_group_d(reg_addr);
  assign wr_ok = reg_wr && !refuse;
  assign sel_flags = (reg_addr == rpsr_pkg::RPSR_OFS_FLAGS);
  assign sel_page = (reg_addr == rpsr_pkg::RPSR_OFS_PAGE);
  assign sel_mode = (reg_addr == rpsr_pkg::RPSR_OFS_MODE);
  assign sel_ptr[0] = (reg_addr == rpsr_pkg::RPSR_OFS_PTR_LOW);
  assign sel_ptr[1] = (reg_addr == rpsr_pkg::RPSR_OFS_PTR_HIGH);
  assign reg_claim = sel_flags || sel_page || sel_mode ||
                     sel_ptr[0] || sel_ptr[1];

  ////////////////////////////////////////////////////////////////////////////
  // condition flags

  logic [7:0] flags_r;
  logic ovf;
  logic nib_carry;
  logic dir_sub;
  logic bcd_upd;

  rpsr_flag_calc u_flag_calc (
    .a(alu_a),
    .b(alu_b),
    .cin(alu_cin),
    .op(alu_op),
    .ovf(ovf),
    .nib_carry(nib_carry),
    .dir_sub(dir_sub),
    .bcd_upd(bcd_upd)
  );

  // a hardware update in the same cycle as a store wins its bits
  always_ff @(posedge clk)
  begin
    if (rst)
      flags_r <= rpsr_pkg::RPSR_RST_FLAGS;
    else if (ce)
    begin
      // bit 1 is stored as written; software is expected to keep it 0
      if (wr_ok && sel_flags)
        flags_r <= reg_wdata;
      if (alu_upd)
        flags_r[rpsr_pkg::RPSR_FLAG_V] <= ovf;
      if (alu_upd && bcd_upd)
      begin
        flags_r[rpsr_pkg::RPSR_FLAG_DA] <= dir_sub;
        flags_r[rpsr_pkg::RPSR_FLAG_H] <= nib_carry;
      end
      if (op_sdm)
        flags_r[rpsr_pkg::RPSR_FLAG_DP] <= 1'b1;
      else if (op_spm)
        flags_r[rpsr_pkg::RPSR_FLAG_DP] <= 1'b0;
    end
  end

  assign condition_flags = flags_r;
  // one is the normal state once start-up code has run
  assign memory_space_select_flag = flags_r[rpsr_pkg::RPSR_FLAG_DP];

  ////////////////////////////////////////////////////////////////////////////
  // working block pointers, low (0) and high (1)

  logic [4:0] blk_r [2];
  logic twin_r [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ptr
      logic load_own;
      assign load_own = (gi == 0) ? op_set_twin_pointer_low : op_set_twin_pointer_high;

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          blk_r[gi] <= rpsr_pkg::RPSR_RST_BLOCK;
          twin_r[gi] <= 1'b0;
        end
        else if (ce)
        begin
          if (op_srp)
          begin
            if (gi == 0)
              blk_r[gi] <= op_block;
            twin_r[gi] <= 1'b0;
          end
          else if (op_set_twin_pointer_low || op_set_twin_pointer_high)
          begin
            if (load_own)
              blk_r[gi] <= op_block;
            twin_r[gi] <= 1'b1;
          end
          else if (wr_ok && sel_ptr[gi])
          begin
            blk_r[gi] <= reg_wdata[rpsr_pkg::RPSR_PTR_BLK_MSB:
                                   rpsr_pkg::RPSR_PTR_BLK_LSB];
            twin_r[gi] <= reg_wdata[rpsr_pkg::RPSR_PTR_TWIN];
          end
        end
      end
    end
  endgenerate

  // the low pointer's selector steers the mapping; the high pointer's copy
  // is only returned by reads of the high pointer register
  assign twin_mode_select = twin_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // working register address translation

  logic [7:0] wr_phys_r;
  logic wr_valid_r;

  // 32 blocks of eight: a 5-bit block number spans the whole file
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_phys_r <= 8'h00;
      wr_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      wr_valid_r <= wr_req;
      if (wr_req)
        wr_phys_r <= work_phys(wr_index, blk_r[0], blk_r[1],
                               twin_r[0]);
    end
  end

  assign wr_phys_addr = wr_phys_r;
  assign wr_phys_valid = wr_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // peripheral page select

  logic [5:0] page_r;

  // held until software writes another page; not saved on interrupt entry
  always_ff @(posedge clk)
  begin
    if (rst)
      page_r <= rpsr_pkg::RPSR_RST_PAGE;
    else if (ce && wr_ok && sel_page)
      page_r <= reg_wdata[rpsr_pkg::RPSR_PAGE_MSB:
                          rpsr_pkg::RPSR_PAGE_LSB];
  end

  assign page_number_field = page_r;

  ////////////////////////////////////////////////////////////////////////////
  // operating mode control

  logic [7:0] mode_r;

  // bits 4:0 belong to other logic; they are kept so reads return them
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_r <= rpsr_pkg::RPSR_RST_MODE;
    else if (ce && wr_ok && sel_mode)
      mode_r <= reg_wdata;
  end

  assign system_stack_location = mode_r[rpsr_pkg::RPSR_MODE_SSTK];
  assign user_stack_location = mode_r[rpsr_pkg::RPSR_MODE_USTK];
  assign oscillator_halving = mode_r[rpsr_pkg::RPSR_MODE_HALF];

  ////////////////////////////////////////////////////////////////////////////
  // oscillator divide-by-two as an enable, no generated clock

  logic osc_phase_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      osc_phase_r <= 1'b0;
    else if (ce)
    begin
      if (oscillator_halving)
        osc_phase_r <= !osc_phase_r;
      else
        osc_phase_r <= 1'b0;
    end
  end

  // every enabled cycle when undivided, every other one when halved
  assign osc_clk_en = ce && (!oscillator_halving || osc_phase_r);

  ////////////////////////////////////////////////////////////////////////////
  // read data and port answers

  logic [7:0] rd_val;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic refused_r;

  always_comb
  begin
    rd_val = 8'h00;
    if (sel_flags)
      rd_val = flags_r;
    else if (sel_ptr[0])
      rd_val = {blk_r[0], twin_r[0], 2'b00};
    else if (sel_ptr[1])
      rd_val = {blk_r[1], twin_r[1], 2'b00};
    else if (sel_page)
      rd_val = {page_r, 2'b00};
    else if (sel_mode)
      rd_val = mode_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_r <= reg_rd && reg_claim && !refuse;
      refused_r <= (reg_rd || reg_wr) && refuse;
      if (reg_rd && reg_claim && !refuse)
        rdata_r <= rd_val;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign reg_refused = refused_r;

endmodule
`default_nettype wire

// *** testbench/rpsr_monitor.sv ***
// Purpose: port-level checks of the system register group
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached by bind from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module rpsr_monitor (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic [7:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic reg_direct, // explicit addressing
  input wire logic reg_claim, // address held here
  input wire logic reg_rvalid, // read valid
  input wire logic reg_refused, // refusal pulse
  input wire logic op_srp, // single pointer
  input wire logic op_set_twin_pointer_low, // twin low
  input wire logic op_set_twin_pointer_high, // twin high
  input wire logic op_sdm, // data memory
  input wire logic op_spm, // program memory
  input wire logic alu_upd, // flag update
  input wire rpsr_pkg::rpsr_alu_e alu_op, // op class
  input wire logic wr_req, // translate request
  input wire logic [3:0] wr_index, // working index
  input wire logic [7:0] wr_phys_addr, // physical address
  input wire logic wr_phys_valid, // address valid
  input wire logic [7:0] condition_flags, // flags
  input wire logic memory_space_select_flag, // space flag
  input wire logic twin_mode_select, // twin mode
  input wire logic [5:0] page_number_field, // page
  input wire logic system_stack_location, // sys stack
  input wire logic user_stack_location, // user stack
  input wire logic oscillator_halving, // halving
  input wire logic osc_clk_en // oscillator enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence rd_take;
    ce && reg_rd && reg_claim;
  endsequence
  sequence d_direct;
    ce && (reg_rd || reg_wr) && reg_direct && reg_addr[7:4] == 4'hD;
  endsequence
  sequence tr_take;
    ce && wr_req;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (rd_take |=> reg_rvalid)
    else $error("read of held register gave no valid pulse");
  group_d_refuse_a: assert property (d_direct |=> reg_refused)
    else $error("direct access to group d not refused");
  twin_set_a: assert property (ce && !op_srp && (op_set_twin_pointer_low || op_set_twin_pointer_high)
    |=> twin_mode_select)
    else $error("twin pointer op left single mode");
  single_clr_a: assert property (ce && op_srp |=> !twin_mode_select)
    else $error("single pointer op left twin mode");
  space_flag_a: assert property (ce && (op_sdm || op_spm) |=>
    memory_space_select_flag == $past(op_sdm))
    else $error("space flag wrong after sdm or spm");
  single_addr_a: assert property (tr_take ##0 !twin_mode_select |=>
    wr_phys_valid && wr_phys_addr[3:0] == $past(wr_index))
    else $error("single mode address low nibble wrong");
  twin_addr_a: assert property (tr_take ##0 twin_mode_select |=>
    wr_phys_valid && wr_phys_addr[2:0] == $past(wr_index[2:0]))
    else $error("twin mode address low bits wrong");
  reset_value_a: assert property ($fell(rst) && $past(ce) |->
    condition_flags == 8'h00 && page_number_field == 6'h00 &&
    system_stack_location && user_stack_location && oscillator_halving)
    else $error("state after reset wrong");
  half_alt_a: assert property (ce && oscillator_halving && osc_clk_en
    |=> (oscillator_halving -> !osc_clk_en))
    else $error("halved enable high two cycles running");
  full_rate_a: assert property (!oscillator_halving |-> osc_clk_en == ce)
    else $error("undivided enable does not follow ce");
  page_load_a: assert property (ce && reg_wr &&
    reg_addr == rpsr_pkg::RPSR_OFS_PAGE |=>
    page_number_field == $past(reg_wdata[7:2]))
    else $error("page field not loaded from write");
  mode_bits_a: assert property (ce && reg_wr &&
    reg_addr == rpsr_pkg::RPSR_OFS_MODE |=> {system_stack_location,
    user_stack_location, oscillator_halving} == $past(reg_wdata[7:5]))
    else $error("mode outputs not loaded from write");
  logic_clr_v_a: assert property (ce && alu_upd &&
    alu_op == rpsr_pkg::RPSR_ALU_LOGIC |=> !condition_flags[4])
    else $error("logical op left overflow set");
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the system register group
// Assumes: fixed one-cycle answers as handed over, 100 MHz clock
// Notes: flag cases come from a table; corner cases are hand written
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct {
    rpsr_pkg::rpsr_alu_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] vdh;
  } rpsr_row_s;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic reg_wr = 1'h0, reg_rd = 1'h0, reg_direct = 1'h0;
  logic op_srp = 1'h0, op_set_twin_pointer_low = 1'h0, op_set_twin_pointer_high = 1'h0;
  logic op_sdm = 1'h0, op_spm = 1'h0, alu_upd = 1'h0, alu_cin = 1'h0;
  logic [4:0] op_block = 5'h00;
  rpsr_pkg::rpsr_alu_e alu_op = rpsr_pkg::RPSR_ALU_ADD;
  logic [7:0] alu_a = 8'h00, alu_b = 8'h00;
  logic wr_req = 1'h0;
  logic [3:0] wr_index = 4'h0;
  logic reg_claim, reg_rvalid, reg_refused, wr_phys_valid;
  logic memory_space_select_flag, twin_mode_select, osc_clk_en;
  logic system_stack_location, user_stack_location, oscillator_halving;
  logic [7:0] reg_rdata, wr_phys_addr, condition_flags, n;
  logic [5:0] page_number_field;
  int num_errors = 0;
  int checks_done = 0;
  // vdh holds the expected overflow, adjust direction and nibble carry
  rpsr_row_s rows [8] = '{
    '{rpsr_pkg::RPSR_ALU_ADD, 8'h7F, 8'h01, 3'h5},
    '{rpsr_pkg::RPSR_ALU_SUB, 8'h80, 8'h01, 3'h7},
    '{rpsr_pkg::RPSR_ALU_ADD, 8'h12, 8'h34, 3'h0},
    '{rpsr_pkg::RPSR_ALU_SUB, 8'h34, 8'h12, 3'h2},
    '{rpsr_pkg::RPSR_ALU_CMP, 8'h80, 8'h01, 3'h6},
    '{rpsr_pkg::RPSR_ALU_LOGIC, 8'h0F, 8'hF0, 3'h2},
    '{rpsr_pkg::RPSR_ALU_SHL, 8'h40, 8'h00, 3'h6},
    '{rpsr_pkg::RPSR_ALU_SHR, 8'hFF, 8'h00, 3'h2}};
  rpsr_core uut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_direct, .reg_claim, .reg_rdata, .reg_rvalid, .reg_refused, .op_srp,
    .op_set_twin_pointer_low, .op_set_twin_pointer_high, .op_block, .op_sdm, .op_spm, .alu_upd, .alu_op,
    .alu_a, .alu_b, .alu_cin, .wr_req, .wr_index, .wr_phys_addr,
    .wr_phys_valid, .condition_flags, .memory_space_select_flag,
    .twin_mode_select, .page_number_field, .system_stack_location,
    .user_stack_location, .oscillator_halving, .osc_clk_en);
  initial
  begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // unheld addresses must give no valid pulse; read data is then ignored
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk("claim", reg_claim, (a >= 8'hE7 && a <= 8'hEB));
    chk("rvalid", reg_rvalid, (a >= 8'hE7 && a <= 8'hEB));
    if (a >= 8'hE7 && a <= 8'hEB)
      chk("rdata", reg_rdata, exp);
  endtask
  task automatic alu(input rpsr_pkg::rpsr_alu_e op, input logic [7:0] a,
    input logic [7:0] b, input logic cin);
    @(posedge clk);
    alu_upd <= 1'h1;
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_cin <= cin;
    @(posedge clk);
    alu_upd <= 1'h0;
    @(negedge clk);
  endtask
  // s is {srp, set_twin_pointer_low, set_twin_pointer_high, sdm, spm}
  task automatic ins(input logic [4:0] s, input logic [4:0] blk);
    @(posedge clk);
    {op_srp, op_set_twin_pointer_low, op_set_twin_pointer_high, op_sdm, op_spm} <= s;
    op_block <= blk;
    @(posedge clk);
    {op_srp, op_set_twin_pointer_low, op_set_twin_pointer_high, op_sdm, op_spm} <= 5'h00;
    @(negedge clk);
  endtask
  task automatic tr(input logic [3:0] idx, input logic [7:0] exp);
    @(posedge clk);
    wr_req <= 1'h1;
    wr_index <= idx;
    @(posedge clk);
    wr_req <= 1'h0;
    @(negedge clk);
    chk("phys valid", wr_phys_valid, 8'h01);
    chk("phys addr", wr_phys_addr, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("mode pins", {system_stack_location, user_stack_location,
      oscillator_halving}, 8'h07);
    rreg(rpsr_pkg::RPSR_OFS_MODE, 8'hE0);
    wreg(rpsr_pkg::RPSR_OFS_FLAGS, 8'hE1); // reserved bit kept 0
    foreach (rows[i])
    begin
      alu(rows[i].op, rows[i].a, rows[i].b, 1'h0);
      chk("v da h", condition_flags[4:2], rows[i].vdh);
    end
    chk("other flags", condition_flags & 8'hE3, 8'hE1);
    // carry and borrow in must reach the nibble and the sign bit
    alu(rpsr_pkg::RPSR_ALU_ADD, 8'h7F, 8'h00, 1'h1);
    chk("adc v da h", condition_flags[4:2], 8'h05);
    alu(rpsr_pkg::RPSR_ALU_SUB, 8'h00, 8'h00, 1'h1);
    chk("sbc v da h", condition_flags[4:2], 8'h03);
    ins(5'h01, 5'h00);
    chk("space flag", memory_space_select_flag, 8'h00);
    ins(5'h03, 5'h00); // leaves the space flag at one
    chk("space flag", memory_space_select_flag, 8'h01);
    ins(5'h10, 5'h03); // high block left alone; both twin bits cleared
    chk("twin", twin_mode_select, 8'h00);
    rreg(rpsr_pkg::RPSR_OFS_PTR_LOW, 8'h18);
    tr(4'h0, 8'h10);
    tr(4'hF, 8'h1F);
    ins(5'h08, 5'h1F);
    ins(5'h04, 5'h1E);
    chk("twin", twin_mode_select, 8'h01);
    rreg(rpsr_pkg::RPSR_OFS_PTR_LOW, 8'hFC);
    rreg(rpsr_pkg::RPSR_OFS_PTR_HIGH, 8'hF4);
    tr(4'h2, 8'hFA);
    tr(4'h9, 8'hF1);
    ins(5'h18, 5'h06);
    chk("twin", twin_mode_select, 8'h00);
    tr(4'h5, 8'h35);
    wreg(rpsr_pkg::RPSR_OFS_PTR_LOW, 8'h4B);
    rreg(rpsr_pkg::RPSR_OFS_PTR_LOW, 8'h48);
    wreg(rpsr_pkg::RPSR_OFS_PAGE, 8'h17); // software keeps page itself
    @(negedge clk);
    chk("page", page_number_field, 8'h05);
    rreg(rpsr_pkg::RPSR_OFS_PAGE, 8'h14);
    wreg(rpsr_pkg::RPSR_OFS_PAGE, 8'hFF);
    rreg(rpsr_pkg::RPSR_OFS_PAGE, 8'hFC);
    @(posedge clk);
    ce <= 1'h0;
    wreg(rpsr_pkg::RPSR_OFS_PAGE, 8'h08);
    ce <= 1'h1;
    rreg(rpsr_pkg::RPSR_OFS_PAGE, 8'hFC);
    rreg(8'h50, 8'h00); // unheld address
    wreg(rpsr_pkg::RPSR_OFS_MODE, 8'h1F);
    rreg(rpsr_pkg::RPSR_OFS_MODE, 8'h1F);
    chk("mode pins", {system_stack_location, user_stack_location,
      oscillator_halving}, 8'h00);
    wreg(rpsr_pkg::RPSR_OFS_MODE, 8'hA0);
    n = 8'h00;
    repeat (4)
    begin
      @(negedge clk);
      n = n + osc_clk_en;
    end
    chk("halved enables", n, 8'h02);
    chk("mode pins", {system_stack_location, user_stack_location,
      oscillator_halving}, 8'h05);
    @(posedge clk);
    reg_direct <= 1'h1;
    wreg(8'hD3, 8'h55);
    @(negedge clk);
    chk("refused", reg_refused, 8'h01);
    @(posedge clk);
    reg_direct <= 1'h0;
    wreg(8'hD3, 8'h55);
    @(negedge clk);
    chk("refused", reg_refused, 8'h00);
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("mode pins", {system_stack_location, user_stack_location,
      oscillator_halving}, 8'h07);
    chk("flags", condition_flags, 8'h00);
    stop_test();
  end
endmodule
bind rpsr_core rpsr_monitor u_mon (.clk, .rst, .ce, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_direct, .reg_claim, .reg_rvalid, .reg_refused,
  .op_srp, .op_set_twin_pointer_low, .op_set_twin_pointer_high, .op_sdm, .op_spm, .alu_upd, .alu_op, .wr_req,
  .wr_index, .wr_phys_addr, .wr_phys_valid, .condition_flags,
  .memory_space_select_flag, .twin_mode_select, .page_number_field,
  .system_stack_location, .user_stack_location, .oscillator_halving,
  .osc_clk_en);
`default_nettype wire
